// *** hdl/pmc_defs.svh ***
// register offsets, field positions, reset values and timing counts of the power mode controller
`ifndef PMC_DEFS_SVH
`define PMC_DEFS_SVH

`define PMC_OFS_MODE 8'h00
`define PMC_OFS_ACT_TMPL 8'h04
`define PMC_OFS_ALT_TMPL 8'h08
`define PMC_OFS_WAKE_EN 8'h0c
`define PMC_OFS_SLEEP_INTV 8'h10
`define PMC_OFS_IRQ_STAT 8'h14
`define PMC_OFS_IRQ_MASK 8'h18
`define PMC_OFS_REG_CTRL 8'h1c
`define PMC_OFS_STATUS 8'h20

`define PMC_NSUB 8
`define PMC_SUB_CPU 0
`define PMC_SUB_FLASH 1
`define PMC_NWAKE 6
`define PMC_WAKE_COMP 0
`define PMC_WAKE_PIN 1
`define PMC_WAKE_I2C 2
`define PMC_WAKE_RTC 3
`define PMC_WAKE_TW 4
`define PMC_WAKE_LOW_VOLT 5
`define PMC_WAKE_RST 6
`define PMC_INTV_W 16

`define PMC_IRQ_SLEEP_WAKE 0
`define PMC_IRQ_HIB_WAKE 1
`define PMC_IRQ_ABORT 2
`define PMC_IRQ_INTV 3
`define PMC_NIRQ 4

`define PMC_ST_BUSY 2
`define PMC_ST_BUZZ 3
`define PMC_ST_HIBREG 4
`define PMC_ST_IOHOLD 5
`define PMC_ST_CPU 6

`define PMC_RST_TMPL 8'hff
`define PMC_RST_SLEEP_KEEP 8'h00
`define PMC_RST_WAKE_EN 7'h7f
`define PMC_RST_INTV 16'h0000
`define PMC_RST_IRQ 4'h0

`define PMC_CLK_PERIOD_NS 100
`define PMC_SLEEP_RESUME_NS 15000
`define PMC_HIB_RESUME_NS 100000
`define PMC_ENTRY_NS 1000
`define PMC_SLEEP_WAKE_CYC ((`PMC_SLEEP_RESUME_NS + `PMC_CLK_PERIOD_NS - 1) / `PMC_CLK_PERIOD_NS)
`define PMC_HIB_WAKE_CYC ((`PMC_HIB_RESUME_NS / `PMC_CLK_PERIOD_NS) - 1)
`define PMC_ENTRY_CYC ((`PMC_ENTRY_NS + `PMC_CLK_PERIOD_NS - 1) / `PMC_CLK_PERIOD_NS)
`define PMC_CNT_W 10

`endif

// *** hdl/pmc_pkg.sv ***
// types shared by the power mode controller and its bench
package pmc_pkg;
	typedef enum logic [1:0] {
		PMC_MODE_ACTIVE = 2'h0,
		PMC_MODE_ALT = 2'h1,
		PMC_MODE_SLEEP = 2'h2,
		PMC_MODE_HIB = 2'h3
	} pmc_mode_t;

	typedef enum logic [2:0] {
		ST_ACTIVE,
		ST_ALT,
		ST_SLEEP_ENTRY,
		ST_SLEEP,
		ST_SLEEP_WAKE,
		ST_HIB_ENTRY,
		ST_HIB,
		ST_HIB_WAKE
	} pmc_state_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} pmc_apb_req_t;

	typedef struct packed {
		logic coreRegEn;
		logic regBuzz;
		logic hibRegOnly;
		logic ioHold;
		logic lowSpeedEn;
		logic clkStop;
	} pmc_pwr_t;
endpackage

// *** hdl/pmc_ctrl.sv ***
// power mode controller: mode sequencing, clock templates, regulator states and apb registers
//
// Notes on behaviour
// - after reset the device sits in active mode, all template bits set
// - in active each subsystem follows its own active template bit, writable anytime
// - a disabled subsystem has its clock gated and its bias-disable raised
// - firmware may clear the cpu bit; the next wakeup sets it again
// - any wakeup returns to active and forces the cpu enabled
// - alternate active applies its own separate template
// - sleep turns off most subsystems regardless of templates, low-speed timing keeps running
// - sleep offers timed intervals and wakes from six enabled sources or the enabled reset event
// - in sleep core regulators are buzzed unless external regulation disabled them
// - sleep resume waits a fixed 15 us wake interval before active
// - the wake interval lets regulators settle before active is entered
// - hibernate stops all clocks, keeps state, only hibernate regulator on
// - in hibernate output pins hold level, pin interrupt setup kept
// - only the pin interrupt leaves hibernate, resume under 100 us
// - each wake source, and the reset event, has its own enable bit
`include "pmc_defs.svh"
`timescale 1ns/1ps
module pmc_ctrl #(
	parameter int NSUB = `PMC_NSUB,
	parameter logic [`PMC_NSUB-1:0] SLEEP_KEEP = `PMC_RST_SLEEP_KEEP
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire pmc_pkg::pmc_apb_req_t apbReq,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [`PMC_NWAKE-1:0] wakeSrcAsync,
	input wire logic resetEvtAsync,
	input wire logic lowSpeedTickAsync,
	output logic [NSUB-1:0] subsysClkEn,
	output logic [NSUB-1:0] biasDis,
	output pmc_pkg::pmc_pwr_t pwrCtl,
	output pmc_pkg::pmc_mode_t curMode,
	output logic irq
);
	import pmc_pkg::*;

	localparam logic [`PMC_CNT_W-1:0] SLEEP_WAKE_CYC = `PMC_CNT_W'(`PMC_SLEEP_WAKE_CYC);
	localparam logic [`PMC_CNT_W-1:0] HIB_WAKE_CYC = `PMC_CNT_W'(`PMC_HIB_WAKE_CYC);
	localparam logic [`PMC_CNT_W-1:0] ENTRY_CYC = `PMC_CNT_W'(`PMC_ENTRY_CYC);

	pmc_state_t state_r;
	logic [`PMC_CNT_W-1:0] waitCnt_r;
	logic [`PMC_INTV_W-1:0] intvCnt_r;
	logic [NSUB-1:0] actTmpl_r;
	logic [NSUB-1:0] altTmpl_r;
	logic [`PMC_NWAKE:0] wakeEn_r;
	logic [`PMC_INTV_W-1:0] sleepIntv_r;
	logic [`PMC_NIRQ-1:0] irqStat_r;
	logic [`PMC_NIRQ-1:0] irqMask_r;
	logic extReg_r;
	logic [`PMC_NWAKE-1:0] wakeMeta_r;
	logic [`PMC_NWAKE-1:0] wakeSync_r;
	logic rstMeta_r;
	logic rstSync_r;
	logic tickMeta_r;
	logic tickSync_r;
	logic tickDly_r;
	logic [NSUB-1:0] clkEn_nxt;
	logic [31:0] rdata_nxt;
	logic addrOk;

	// slow pins and the oscillator tick come from other domains
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			wakeMeta_r <= '0;
			wakeSync_r <= '0;
			rstMeta_r <= 1'b0;
			rstSync_r <= 1'b0;
			tickMeta_r <= 1'b0;
			tickSync_r <= 1'b0;
			tickDly_r <= 1'b0;
		end else begin
			wakeMeta_r <= wakeSrcAsync;
			wakeSync_r <= wakeMeta_r;
			rstMeta_r <= resetEvtAsync;
			rstSync_r <= rstMeta_r;
			tickMeta_r <= lowSpeedTickAsync;
			tickSync_r <= tickMeta_r;
			tickDly_r <= tickSync_r;
		end
	end

	wire lsTick = tickSync_r & ~tickDly_r;

	// apb: one-wait-state slave with pready raised one cycle into the access phase
	wire setupPh = apbReq.psel & ~apbReq.penable;
	wire accDone = apbReq.psel & apbReq.penable & pready;
	wire wrEn = accDone & apbReq.pwrite;
	wire rdEn = accDone & ~apbReq.pwrite;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction

	wire wrMode = wrEn & hit(apbReq.paddr, `PMC_OFS_MODE);
	wire [1:0] reqCode = apbReq.pwdata[1:0];

	// wake qualification
	wire wakeAny = (|(wakeSync_r & wakeEn_r[`PMC_NWAKE-1:0])) | (rstSync_r & wakeEn_r[`PMC_WAKE_RST]);
	wire intvDone = (state_r == ST_SLEEP) & (sleepIntv_r != '0) & (intvCnt_r == '0);
	wire sleepWake = (state_r == ST_SLEEP) & (wakeAny | intvDone);
	wire hibWake = (state_r == ST_HIB) & wakeSync_r[`PMC_WAKE_PIN] & wakeEn_r[`PMC_WAKE_PIN];
	wire entryAbort = ((state_r == ST_SLEEP_ENTRY) | (state_r == ST_HIB_ENTRY)) & wakeAny;
	wire waitDone = (waitCnt_r == '0);
	wire resumeDone = ((state_r == ST_SLEEP_WAKE) | (state_r == ST_HIB_WAKE)) & waitDone;
	// any wake that lands in active, or hits active itself, brings the cpu back
	wire cpuRestore = resumeDone | entryAbort | (((state_r == ST_ACTIVE) | (state_r == ST_ALT)) & wakeAny);
	wire busy = (state_r == ST_SLEEP_ENTRY) | (state_r == ST_HIB_ENTRY) |
		(state_r == ST_SLEEP_WAKE) | (state_r == ST_HIB_WAKE);

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			state_r <= ST_ACTIVE;
			waitCnt_r <= '0;
		end else begin
			case (state_r)
				ST_ACTIVE: begin
					if (wrMode) begin
						case (reqCode)
							PMC_MODE_ALT: state_r <= ST_ALT;
							PMC_MODE_SLEEP: begin
								state_r <= ST_SLEEP_ENTRY;
								waitCnt_r <= ENTRY_CYC;
							end
							PMC_MODE_HIB: begin
								state_r <= ST_HIB_ENTRY;
								waitCnt_r <= ENTRY_CYC;
							end
							default: state_r <= ST_ACTIVE;
						endcase
					end
				end
				ST_ALT: begin
					if (wakeAny) begin
						state_r <= ST_ACTIVE;
					end else if (wrMode) begin
						case (reqCode)
							PMC_MODE_ACTIVE: state_r <= ST_ACTIVE;
							PMC_MODE_SLEEP: begin
								state_r <= ST_SLEEP_ENTRY;
								waitCnt_r <= ENTRY_CYC;
							end
							PMC_MODE_HIB: begin
								state_r <= ST_HIB_ENTRY;
								waitCnt_r <= ENTRY_CYC;
							end
							default: state_r <= ST_ALT;
						endcase
					end
				end
				ST_SLEEP_ENTRY: begin
					if (entryAbort) begin
						state_r <= ST_ACTIVE;
					end else if (waitDone) begin
						state_r <= ST_SLEEP;
					end else begin
						waitCnt_r <= waitCnt_r - 1'b1;
					end
				end
				ST_SLEEP: begin
					if (sleepWake) begin
						state_r <= ST_SLEEP_WAKE;
						waitCnt_r <= SLEEP_WAKE_CYC - 1'b1;
					end
				end
				ST_SLEEP_WAKE: begin
					// regulators come out of buzz first; active only after they settle
					if (waitDone) begin
						state_r <= ST_ACTIVE;
					end else begin
						waitCnt_r <= waitCnt_r - 1'b1;
					end
				end
				ST_HIB_ENTRY: begin
					if (entryAbort) begin
						state_r <= ST_ACTIVE;
					end else if (waitDone) begin
						state_r <= ST_HIB;
					end else begin
						waitCnt_r <= waitCnt_r - 1'b1;
					end
				end
				ST_HIB: begin
					if (hibWake) begin
						state_r <= ST_HIB_WAKE;
						waitCnt_r <= HIB_WAKE_CYC - 1'b1;
					end
				end
				ST_HIB_WAKE: begin
					if (waitDone) begin
						state_r <= ST_ACTIVE;
					end else begin
						waitCnt_r <= waitCnt_r - 1'b1;
					end
				end
				default: state_r <= ST_ACTIVE;
			endcase
		end
	end

	// sleep interval counts low-speed ticks, so it keeps time while the core clocks are off
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			intvCnt_r <= `PMC_RST_INTV;
		end else if (state_r == ST_SLEEP_ENTRY) begin
			intvCnt_r <= sleepIntv_r;
		end else if (state_r == ST_SLEEP && lsTick && intvCnt_r != '0) begin
			intvCnt_r <= intvCnt_r - 1'b1;
		end
	end

	// templates: a hardware cpu restore wins over a firmware write in the same cycle
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			actTmpl_r <= NSUB'(`PMC_RST_TMPL);
			altTmpl_r <= NSUB'(`PMC_RST_TMPL);
		end else begin
			if (wrEn && hit(apbReq.paddr, `PMC_OFS_ACT_TMPL)) begin
				actTmpl_r <= apbReq.pwdata[NSUB-1:0];
			end
			if (cpuRestore) begin
				actTmpl_r[`PMC_SUB_CPU] <= 1'b1;
			end
			if (wrEn && hit(apbReq.paddr, `PMC_OFS_ALT_TMPL)) begin
				altTmpl_r <= apbReq.pwdata[NSUB-1:0];
			end
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			wakeEn_r <= `PMC_RST_WAKE_EN;
			sleepIntv_r <= `PMC_RST_INTV;
			irqMask_r <= `PMC_RST_IRQ;
			extReg_r <= 1'b0;
		end else if (wrEn) begin
			if (hit(apbReq.paddr, `PMC_OFS_WAKE_EN)) begin
				wakeEn_r <= apbReq.pwdata[`PMC_NWAKE:0];
			end
			if (hit(apbReq.paddr, `PMC_OFS_SLEEP_INTV)) begin
				sleepIntv_r <= apbReq.pwdata[`PMC_INTV_W-1:0];
			end
			if (hit(apbReq.paddr, `PMC_OFS_IRQ_MASK)) begin
				irqMask_r <= apbReq.pwdata[`PMC_NIRQ-1:0];
			end
			if (hit(apbReq.paddr, `PMC_OFS_REG_CTRL)) begin
				extReg_r <= apbReq.pwdata[0];
			end
		end
	end

	// sticky events, write one to clear; a new event in the clearing cycle survives
	wire [`PMC_NIRQ-1:0] irqSet = {intvDone & (state_r == ST_SLEEP), entryAbort,
		(state_r == ST_HIB_WAKE) & waitDone, (state_r == ST_SLEEP_WAKE) & waitDone};
	wire [`PMC_NIRQ-1:0] irqClr = (wrEn && hit(apbReq.paddr, `PMC_OFS_IRQ_STAT)) ?
		apbReq.pwdata[`PMC_NIRQ-1:0] : '0;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			irqStat_r <= `PMC_RST_IRQ;
			irq <= 1'b0;
		end else begin
			irqStat_r <= (irqStat_r & ~irqClr) | irqSet;
			irq <= |(((irqStat_r & ~irqClr) | irqSet) & irqMask_r);
		end
	end

	// clock enables follow the mode; entry states hold the previous set until committed
	always_comb begin
		clkEn_nxt = subsysClkEn;
		case (state_r)
			ST_ACTIVE: clkEn_nxt = actTmpl_r;
			ST_ALT: clkEn_nxt = altTmpl_r;
			ST_SLEEP, ST_SLEEP_WAKE: clkEn_nxt = SLEEP_KEEP[NSUB-1:0];
			ST_HIB, ST_HIB_WAKE: clkEn_nxt = '0;
			default: clkEn_nxt = subsysClkEn;
		endcase
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			subsysClkEn <= NSUB'(`PMC_RST_TMPL);
			biasDis <= ~NSUB'(`PMC_RST_TMPL);
			curMode <= PMC_MODE_ACTIVE;
			pwrCtl <= '{coreRegEn: 1'b1, regBuzz: 1'b0, hibRegOnly: 1'b0, ioHold: 1'b0,
				lowSpeedEn: 1'b1, clkStop: 1'b0};
		end else begin
			subsysClkEn <= clkEn_nxt;
			biasDis <= ~clkEn_nxt;
			case (state_r)
				ST_ACTIVE: curMode <= PMC_MODE_ACTIVE;
				ST_ALT: curMode <= PMC_MODE_ALT;
				ST_SLEEP, ST_SLEEP_WAKE: curMode <= PMC_MODE_SLEEP;
				ST_HIB, ST_HIB_WAKE: curMode <= PMC_MODE_HIB;
				default: curMode <= curMode;
			endcase
			pwrCtl.coreRegEn <= ~extReg_r & (state_r != ST_HIB) & (state_r != ST_HIB_WAKE);
			pwrCtl.regBuzz <= ~extReg_r & (state_r == ST_SLEEP);
			pwrCtl.hibRegOnly <= (state_r == ST_HIB);
			pwrCtl.ioHold <= (state_r == ST_HIB) | (state_r == ST_HIB_WAKE);
			pwrCtl.lowSpeedEn <= (state_r != ST_HIB) & (state_r != ST_HIB_WAKE);
			pwrCtl.clkStop <= (state_r == ST_HIB);
		end
	end

	always_comb begin
		rdata_nxt = 32'h0000_0000;
		addrOk = 1'b1;
		case (apbReq.paddr)
			`PMC_OFS_MODE: rdata_nxt[1:0] = curMode;
			`PMC_OFS_ACT_TMPL: rdata_nxt[NSUB-1:0] = actTmpl_r;
			`PMC_OFS_ALT_TMPL: rdata_nxt[NSUB-1:0] = altTmpl_r;
			`PMC_OFS_WAKE_EN: rdata_nxt[`PMC_NWAKE:0] = wakeEn_r;
			`PMC_OFS_SLEEP_INTV: rdata_nxt[`PMC_INTV_W-1:0] = sleepIntv_r;
			`PMC_OFS_IRQ_STAT: rdata_nxt[`PMC_NIRQ-1:0] = irqStat_r;
			`PMC_OFS_IRQ_MASK: rdata_nxt[`PMC_NIRQ-1:0] = irqMask_r;
			`PMC_OFS_REG_CTRL: rdata_nxt[0] = extReg_r;
			`PMC_OFS_STATUS: begin
				rdata_nxt[1:0] = curMode;
				rdata_nxt[`PMC_ST_BUSY] = busy;
				rdata_nxt[`PMC_ST_BUZZ] = pwrCtl.regBuzz;
				rdata_nxt[`PMC_ST_HIBREG] = pwrCtl.hibRegOnly;
				rdata_nxt[`PMC_ST_IOHOLD] = pwrCtl.ioHold;
				rdata_nxt[`PMC_ST_CPU] = subsysClkEn[`PMC_SUB_CPU];
			end
			default: addrOk = 1'b0;
		endcase
	end

	// read data and error are captured at setup so they are stable through the access phase
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= apbReq.psel & apbReq.penable & ~pready;
			if (setupPh) begin
				prdata <= apbReq.pwrite ? 32'h0000_0000 : rdata_nxt;
				pslverr <= ~addrOk;
			end else if (rdEn | wrEn) begin
				pslverr <= 1'b0;
			end
		end
	end
endmodule

// *** verification/pmc_ctrl_properties.sv ***
// concurrent checks on the power mode controller ports
`timescale 1ns/1ps
module pmc_ctrl_properties #(
	parameter int NSUB = 8,
	parameter logic [7:0] SLEEP_KEEP = 8'h00
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire pmc_pkg::pmc_apb_req_t apbReq,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [5:0] wakeSrcAsync,
	input wire logic resetEvtAsync,
	input wire logic lowSpeedTickAsync,
	input wire logic [NSUB-1:0] subsysClkEn,
	input wire logic [NSUB-1:0] biasDis,
	input wire pmc_pkg::pmc_pwr_t pwrCtl,
	input wire pmc_pkg::pmc_mode_t curMode,
	input wire logic irq
);
	import pmc_pkg::*;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	// the buzz output drops when the wake interval starts, so it marks the start of resume
	sequence s_resume_start;
		$fell(pwrCtl.regBuzz) && curMode == PMC_MODE_SLEEP;
	endsequence
	sequence s_back_active;
		##[148:152] curMode == PMC_MODE_ACTIVE;
	endsequence
	a_bias_tracks_clk: assert property (biasDis == ~subsysClkEn)
		else $error("bias disable is not the inverse of clock enable");
	a_boot_active: assert property (!$past(resetn) |-> curMode == PMC_MODE_ACTIVE && subsysClkEn == '1)
		else $error("not active with all subsystems after reset");
	a_sleep_gated: assert property (curMode == PMC_MODE_SLEEP |-> subsysClkEn == SLEEP_KEEP)
		else $error("subsystem clocked during sleep");
	a_buzz_only_sleep: assert property (pwrCtl.regBuzz |-> curMode == PMC_MODE_SLEEP)
		else $error("regulator buzzed outside sleep");
	a_hib_retained: assert property ($rose(curMode == PMC_MODE_HIB) |->
		pwrCtl.hibRegOnly && pwrCtl.clkStop && pwrCtl.ioHold && subsysClkEn == '0)
		else $error("hibernate entered without clock stop and hold");
	a_wake_cpu_on: assert property (curMode == PMC_MODE_ACTIVE && $past(curMode) != PMC_MODE_ACTIVE |->
		subsysClkEn[0])
		else $error("cpu not enabled on return to active");
	a_sleep_resume: assert property (s_resume_start |-> s_back_active)
		else $error("sleep resume interval wrong");
	a_resume_waits: assert property (s_resume_start |=> (curMode == PMC_MODE_SLEEP) [*8])
		else $error("active entered before regulators settle");
	a_hib_exit_active: assert property ($past(curMode) == PMC_MODE_HIB && curMode != PMC_MODE_HIB |->
		curMode == PMC_MODE_ACTIVE)
		else $error("hibernate left to a mode other than active");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_ready_in_access: assert property (pready |-> apbReq.psel && apbReq.penable && $past(apbReq.penable))
		else $error("pready outside access phase");
endmodule

// *** verification/test_power_mode_controller.sv ***
// self-checking bench of the power mode controller
`include "pmc_defs.svh"
`timescale 1ns/1ps
module test_power_mode_controller;
	import pmc_pkg::*;
	localparam int NSUB = 8;
	localparam logic [7:0] SLEEP_KEEP = 8'h00;
	logic clk_sys, resetn, pready, pslverr, irq, rdErr, tick, rstEvt;
	pmc_apb_req_t req;
	logic [31:0] prdata, rdData;
	logic [5:0] wake;
	logic [7:0] clkEn, biasDis;
	pmc_pwr_t pwr;
	pmc_mode_t mode;
	int n_errors = 0, n_tests = 0, cnt;
	pmc_ctrl #(.NSUB(NSUB), .SLEEP_KEEP(SLEEP_KEEP)) dut_u (.clk_sys(clk_sys), .resetn(resetn), .apbReq(req),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .wakeSrcAsync(wake), .resetEvtAsync(rstEvt),
		.lowSpeedTickAsync(tick), .subsysClkEn(clkEn), .biasDis(biasDis), .pwrCtl(pwr), .curMode(mode), .irq(irq));
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	task complete_run;
		$display("errors %0d tests %0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task fail(input string s);
		n_errors++;
		$display("BAD %0t %s", $time, s);
		complete_run();
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	// outputs read right after an edge still show their pre-edge, sampled value
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge clk_sys);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge clk_sys);
		req.penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge clk_sys);
			if (pready === 1'b1) break;
		end
		if (i == 20) fail("apb timeout");
		rdData = prdata;
		rdErr = pslverr;
		req <= '0;
	endtask
	task waitMode(input pmc_mode_t m, input int lim);
		cnt = 0;
		while (mode !== m) begin
			@(posedge clk_sys);
			cnt++;
			if (cnt > lim) fail("mode wait timeout");
		end
	endtask
	task t_reset;
		chk(mode, PMC_MODE_ACTIVE);
		chk(clkEn, 8'hff);
		apb(0, `PMC_OFS_ACT_TMPL, 0);
		chk(rdData, 32'h0000_00ff);
		apb(0, `PMC_OFS_WAKE_EN, 0);
		chk(rdData, 32'h0000_007f);
		cyc(50);
		chk(mode, PMC_MODE_ACTIVE);
	endtask
	task t_active;
		apb(1, `PMC_OFS_ACT_TMPL, 32'h0000_00a4);
		cyc(2);
		chk(clkEn, 8'ha4);
		chk(biasDis, 8'h5b);
		apb(0, 8'h40, 0);
		chk(rdErr, 1'b1);
		chk(rdData, 0);
	endtask
	task t_alt;
		apb(1, `PMC_OFS_ALT_TMPL, 32'h0000_003c);
		apb(1, `PMC_OFS_MODE, PMC_MODE_ALT);
		waitMode(PMC_MODE_ALT, 20);
		cyc(2);
		chk(clkEn, 8'h3c);
		apb(0, `PMC_OFS_STATUS, 0);
		chk(rdData, 32'h0000_0001);
		wake <= 6'h01;
		waitMode(PMC_MODE_ACTIVE, 20);
		wake <= 6'h00;
		cyc(2);
		chk(clkEn, 8'ha5);
	endtask
	task sleepOnce(input logic [5:0] src);
		apb(1, `PMC_OFS_ACT_TMPL, 32'h0000_00a4);
		// io supplies are taken as valid from reset on
		apb(1, `PMC_OFS_MODE, PMC_MODE_SLEEP);
		waitMode(PMC_MODE_SLEEP, 40);
		cyc(2);
		chk(clkEn, SLEEP_KEEP);
		chk(pwr.regBuzz, 1'b1);
		chk(pwr.coreRegEn, 1'b1);
		chk(pwr.lowSpeedEn, 1'b1);
		wake <= src;
	endtask
	task t_sleep;
		apb(1, `PMC_OFS_IRQ_MASK, 32'h1);
		for (int i = 0; i < 6; i++) begin
			sleepOnce(6'h01 << i);
			waitMode(PMC_MODE_ACTIVE, 300);
			wake <= 6'h00;
			chk(cnt >= 150 && cnt <= 160, 1'b1);
			cyc(2);
			chk(clkEn, 8'ha5);
			chk(irq, 1'b1);
			apb(1, `PMC_OFS_IRQ_STAT, 32'h1);
			cyc(2);
			chk(irq, 1'b0);
		end
		// a source whose enable is cleared must not end sleep
		apb(1, `PMC_OFS_WAKE_EN, 32'h37);
		sleepOnce(6'h08);
		rstEvt <= 1'b1;
		cyc(100);
		chk(mode, PMC_MODE_SLEEP);
		rstEvt <= 1'b0;
		wake <= 6'h02;
		waitMode(PMC_MODE_ACTIVE, 300);
		wake <= 6'h00;
		apb(1, `PMC_OFS_WAKE_EN, 32'h7f);
		apb(1, `PMC_OFS_IRQ_STAT, 32'hf);
	endtask
	task t_hib;
		apb(1, `PMC_OFS_IRQ_MASK, 32'h2);
		apb(1, `PMC_OFS_MODE, PMC_MODE_HIB);
		waitMode(PMC_MODE_HIB, 40);
		cyc(2);
		chk(pwr.hibRegOnly, 1'b1);
		chk(pwr.clkStop, 1'b1);
		chk(pwr.ioHold, 1'b1);
		chk(clkEn, 8'h00);
		chk(pwr.coreRegEn, 1'b0);
		wake <= 6'h3d;
		cyc(50);
		chk(mode, PMC_MODE_HIB);
		// the other pins stay high, so nothing toggles fast while hibernating
		wake <= 6'h3f;
		waitMode(PMC_MODE_ACTIVE, 1100);
		wake <= 6'h00;
		chk(cnt <= 1005, 1'b1);
		cyc(2);
		chk(irq, 1'b1);
		apb(1, `PMC_OFS_IRQ_STAT, 32'h2);
	endtask
	task t_abort;
		apb(1, `PMC_OFS_IRQ_MASK, 32'h4);
		apb(1, `PMC_OFS_MODE, PMC_MODE_SLEEP);
		cyc(3);
		wake <= 6'h01;
		cyc(30);
		wake <= 6'h00;
		chk(mode, PMC_MODE_ACTIVE);
		chk(irq, 1'b1);
		apb(0, `PMC_OFS_IRQ_STAT, 0);
		chk(rdData[2], 1'b1);
	endtask
	task pulse(input int n);
		repeat (n) begin
			tick <= 1'b1;
			cyc(3);
			tick <= 1'b0;
			cyc(3);
		end
	endtask
	// timed wake on low-speed ticks, then external regulation with a reset-event wake
	task t_timer;
		apb(1, `PMC_OFS_SLEEP_INTV, 32'h3);
		sleepOnce(6'h00);
		pulse(2);
		cyc(20);
		chk(mode, PMC_MODE_SLEEP);
		pulse(1);
		waitMode(PMC_MODE_ACTIVE, 300);
		apb(0, `PMC_OFS_IRQ_STAT, 0);
		chk(rdData[3], 1'b1);
		apb(1, `PMC_OFS_SLEEP_INTV, 0);
		apb(1, `PMC_OFS_IRQ_STAT, 32'hf);
		apb(1, `PMC_OFS_REG_CTRL, 32'h1);
		apb(1, `PMC_OFS_MODE, PMC_MODE_SLEEP);
		waitMode(PMC_MODE_SLEEP, 40);
		cyc(2);
		chk(pwr.regBuzz, 1'b0);
		chk(pwr.coreRegEn, 1'b0);
		rstEvt <= 1'b1;
		waitMode(PMC_MODE_ACTIVE, 300);
		rstEvt <= 1'b0;
		chk(cnt >= 150 && cnt <= 160, 1'b1);
		apb(1, `PMC_OFS_REG_CTRL, 0);
	endtask
	initial begin
		resetn = 1'b0;
		req = '0;
		wake = 6'h00;
		tick = 1'b0;
		rstEvt = 1'b0;
		cyc(6);
		resetn <= 1'b1;
		t_reset();
		t_active();
		t_alt();
		t_sleep();
		t_hib();
		t_abort();
		t_timer();
		complete_run();
	end
endmodule
bind pmc_ctrl pmc_ctrl_properties #(.NSUB(NSUB), .SLEEP_KEEP(SLEEP_KEEP)) u_props (.clk_sys(clk_sys),
	.resetn(resetn), .apbReq(apbReq), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.wakeSrcAsync(wakeSrcAsync), .resetEvtAsync(resetEvtAsync), .lowSpeedTickAsync(lowSpeedTickAsync),
	.subsysClkEn(subsysClkEn), .biasDis(biasDis), .pwrCtl(pwrCtl), .curMode(curMode), .irq(irq));
